// ---- design/tbac_pkg.sv ----
// Constants, types and register map of the Type B card anticollision block
// Operation
// - ACTIVE: stay silent after bad CRC or CID
// - ACTIVE: valid DESELECT moves card to HALT
// - ACTIVE: never answer REQB, WUPB, marker, ATTRIB
// - ACTIVE leaves only on higher-layer command, valid DESELECT or field loss
// - HALT: only WUPB accepted, returns to IDLE; code takes the request's next state, DECLARED for N=1
// - HALT: field loss returns to POWER_OFF
// - Bad identifiers or CRC: discard, no effect
// - N equal one: send ATQB, enter DECLARED
// - N above one: draw R, R=1 sends
// - R above one: probabilistic idles, marker waits
// - Timed slots: 32 guard, 240 slot, 10 quiet
// - Slot R follows slot R-1 directly
// - Extended profile: PARAM b5 selects timed slots
// - Request is prefix, AFI, PARAM, two CRC
// - Request prefix byte equals 05
// - AFI 00 matches all, else application match
// - AFI nibbles: family, sub-family, zero wildcard; code treats only a zero sub-family nibble as wildcard
// - Extended profile: only AFI 00 accepted
// - PARAM b4: REQB or WUPB, HALT needs WUPB
// - PARAM b3..b1 code slot count 1..16
// - Field loss forces POWER_OFF from anywhere
// - Anticollision frames must start with 101
// - DECLARED: ATTRIB with own PUPI enters ACTIVE
// - DECLARED: matching HLTB enters HALT
package tbac_pkg;

    typedef enum logic [2:0] {
        ST_OFF, ST_IDLE, ST_WAIT_MARK, ST_WAIT_SLOT, ST_DECL, ST_ACTIVE, ST_HALT
    } tbac_state_t;

    typedef struct packed {
        logic sof;
        logic valid;
        logic [7:0] data;
        logic eof;
        logic crc_ok;
        logic fmt_ok;
    } tbac_rx_t;

    // ==========================================================
    // Frame coding
    localparam logic [7:0] PFX_REQ = 8'h05;
    localparam logic [3:0] AP_LOW = 4'h5;
    localparam logic [2:0] ANTI_BITS = 3'h5;
    localparam logic [7:0] CMD_ATTRIB = 8'h1D;
    localparam logic [7:0] CMD_HLTB = 8'h50;
    localparam logic [7:0] PCB_DESEL = 8'hC2;
    localparam logic [7:0] PCB_CID_MASK = 8'hF7;
    localparam int PCB_CID_BIT = 3;
    localparam logic [3:0] LEN_REQ = 4'h5;
    localparam logic [3:0] LEN_MARK = 4'h3;
    localparam logic [3:0] LEN_HLTB = 4'h7;
    localparam logic [3:0] LEN_ATTRIB_MIN = 4'hB;
    localparam logic [3:0] LEN_DESEL_MIN = 4'h3;
    localparam logic [3:0] LEN_MAX = 4'hF;
    localparam int FRAME_BYTES = 10;
    localparam int ATTRIB_CID_BYTE = 8;
    localparam int PARAM_WUPB_BIT = 3;
    localparam int PARAM_TIMED_BIT = 4;
    localparam logic [2:0] N_CODE_MAX = 3'h4;

    // ==========================================================
    // Etu timing, counted in etu
    localparam logic [11:0] ETU_GUARD = 12'h020;
    localparam logic [11:0] ETU_SLOT = 12'h0F0;
    localparam logic [11:0] ETU_CLOSE = 12'h00A;
    localparam logic [11:0] ETU_OPEN = ETU_SLOT - ETU_CLOSE;
    localparam logic [11:0] ETU_SAT = 12'hFFF;

    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PUPI = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_HLCMD = 8'h0C;
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_MARK_BIT = 1;
    localparam int CTRL_AFI_LSB = 8;
    localparam int HL_IDLE_BIT = 0;
    localparam int HL_HALT_BIT = 1;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PUPI_RST = 32'h0000_0000;

endpackage : tbac_pkg

// ---- design/tbac_card.sv ----
// Card-side Type B anticollision state machine with APB control
module tbac_card (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic field_on,
    input wire logic etu_clk,
    input wire tbac_pkg::tbac_rx_t rx,
    output logic tx_atqb,
    output logic tx_gate,
    output logic hl_rx_ok,
    output tbac_pkg::tbac_state_t card_state
);
    import tbac_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic fld_s1_q, fld_s2_q;
    logic etu_s1_q, etu_s2_q, etu_s3_q;
    logic etu_tick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fld_s1_q <= 1'b0;
            fld_s2_q <= 1'b0;
            etu_s1_q <= 1'b0;
            etu_s2_q <= 1'b0;
            etu_s3_q <= 1'b0;
        end else begin
            fld_s1_q <= field_on;
            fld_s2_q <= fld_s1_q;
            etu_s1_q <= etu_clk;
            etu_s2_q <= etu_s1_q;
            etu_s3_q <= etu_s2_q;
        end
    end

    assign etu_tick = etu_s2_q & ~etu_s3_q;

    // ==========================================================
    // APB registers
    logic [31:0] ctrl_q, pupi_q, rd_d;
    logic pready_q, pslverr_q, hl_idle_q, hl_halt_q;
    logic [31:0] prdata_q;
    logic apb_acc, apb_done, addr_ok;
    tbac_state_t state_q, state_d;
    logic [3:0] cid_q;

    assign apb_acc = psel & penable;
    assign apb_done = apb_acc & pready_q;
    assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_PUPI) ||
                     (paddr == REG_STATUS) || (paddr == REG_HLCMD);

    always_comb begin
        case (paddr)
            REG_CTRL: rd_d = ctrl_q;
            REG_PUPI: rd_d = pupi_q;
            REG_STATUS: rd_d = {20'h00000, cid_q, 5'h00, 3'(state_q)};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One wait state so read data leaves a flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_acc & ~pready_q;
            pslverr_q <= apb_acc & ~pready_q & ~addr_ok;
            prdata_q <= (apb_acc & ~pready_q & ~pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RST;
            pupi_q <= PUPI_RST;
            hl_idle_q <= 1'b0;
            hl_halt_q <= 1'b0;
        end else begin
            hl_idle_q <= 1'b0;
            hl_halt_q <= 1'b0;
            if (apb_done && pwrite) begin
                if (paddr == REG_CTRL) begin
                    ctrl_q <= pwdata;
                end
                // Identifier may only change in POWER_OFF or IDLE
                if (paddr == REG_PUPI && (state_q == ST_IDLE || state_q == ST_OFF)) begin
                    pupi_q <= pwdata;
                end
                if (paddr == REG_HLCMD) begin
                    hl_idle_q <= pwdata[HL_IDLE_BIT];
                    hl_halt_q <= pwdata[HL_HALT_BIT];
                end
            end
        end
    end

    logic ext_mode, mark_mode;
    logic [7:0] own_afi;
    assign ext_mode = ctrl_q[CTRL_EXT_BIT];
    assign mark_mode = ctrl_q[CTRL_MARK_BIT];
    assign own_afi = ctrl_q[CTRL_AFI_LSB +: 8];

    // ==========================================================
    // Frame capture
    logic [7:0] fr_q [FRAME_BYTES];
    logic [3:0] len_q;
    logic fr_ok;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            len_q <= 4'h0;
            for (int i = 0; i < FRAME_BYTES; i++) begin
                fr_q[i] <= 8'h00;
            end
        end else if (rx.sof) begin
            len_q <= 4'h0;
        end else if (rx.valid) begin
            if (len_q < 4'(FRAME_BYTES)) begin
                fr_q[len_q] <= rx.data;
            end
            if (len_q != LEN_MAX) begin
                len_q <= len_q + 4'h1;
            end
        end
    end

    assign fr_ok = rx.eof & rx.crc_ok & rx.fmt_ok;

    // ==========================================================
    // Random slot draw
    logic [15:0] lfsr_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
        end
    end

    // ==========================================================
    // Command decode
    logic anti_ok, req_ok, afi_ok, wupb, timed_req, req_take, mark_hit;
    logic id_match, attrib_hit, hltb_hit, cid_ok, desel, anti_like, hl_frame;
    logic [2:0] n_code;
    logic [3:0] n_mask, slot_d, slot_q;
    logic [7:0] req_afi;
    tbac_state_t req_next;

    always_comb begin
        anti_ok = fr_q[0][2:0] == ANTI_BITS;
        n_code = fr_q[2][2:0];
        req_afi = fr_q[1];
        wupb = fr_q[2][PARAM_WUPB_BIT];
        timed_req = ext_mode & fr_q[2][PARAM_TIMED_BIT];
        req_ok = (len_q == LEN_REQ) && (fr_q[0] == PFX_REQ) && anti_ok &&
                 (n_code <= N_CODE_MAX);
        if (ext_mode) begin
            afi_ok = req_afi == 8'h00;
        end else if (req_afi == 8'h00) begin
            afi_ok = 1'b1;
        end else if (req_afi[3:0] == 4'h0) begin
            afi_ok = own_afi[7:4] == req_afi[7:4];
        end else begin
            afi_ok = own_afi == req_afi;
        end
        case (state_q)
            ST_IDLE, ST_WAIT_MARK, ST_WAIT_SLOT, ST_DECL: req_take = req_ok & afi_ok;
            ST_HALT: req_take = req_ok & afi_ok & wupb;
            default: req_take = 1'b0;
        endcase
        n_mask = 4'((5'h01 << n_code) - 5'h01);
        slot_d = lfsr_q[3:0] & n_mask;
        if (n_code == 3'h0) begin
            req_next = ST_DECL;
        end else if (timed_req) begin
            req_next = ST_WAIT_SLOT;
        end else if (slot_d == 4'h0) begin
            req_next = ST_DECL;
        end else if (mark_mode) begin
            req_next = ST_WAIT_MARK;
        end else begin
            req_next = ST_IDLE;
        end
        mark_hit = mark_mode && (len_q == LEN_MARK) && anti_ok &&
                   (fr_q[0][3:0] == AP_LOW) && (fr_q[0][7:4] == slot_q);
        id_match = {fr_q[1], fr_q[2], fr_q[3], fr_q[4]} == pupi_q;
        attrib_hit = (len_q >= LEN_ATTRIB_MIN) && (fr_q[0] == CMD_ATTRIB) && id_match;
        hltb_hit = (len_q == LEN_HLTB) && (fr_q[0] == CMD_HLTB) && id_match;
        cid_ok = fr_q[0][PCB_CID_BIT] ? (fr_q[1][3:0] == cid_q) : (cid_q == 4'h0);
        desel = ((fr_q[0] & PCB_CID_MASK) == PCB_DESEL) && (len_q >= LEN_DESEL_MIN);
        anti_like = req_ok || (fr_q[0] == CMD_ATTRIB) ||
                    ((len_q == LEN_MARK) && (fr_q[0][3:0] == AP_LOW));
        hl_frame = (state_q == ST_ACTIVE) && fr_ok && cid_ok && !anti_like && !desel;
    end

    // ==========================================================
    // Etu timing
    logic [11:0] etu_cnt_q, start_q, close_q;
    logic slot_due, timed_q, send_d;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            etu_cnt_q <= 12'h000;
        end else if (fr_ok) begin
            etu_cnt_q <= 12'h000;
        end else if (etu_tick && etu_cnt_q != ETU_SAT) begin
            etu_cnt_q <= etu_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_q <= 4'h0;
            start_q <= 12'h000;
            close_q <= 12'h000;
        end else if (fr_ok && req_take) begin
            slot_q <= slot_d;
            start_q <= ETU_GUARD + 12'(ETU_SLOT * {8'h00, slot_d});
            close_q <= ETU_GUARD + 12'(ETU_SLOT * {8'h00, slot_d}) + ETU_OPEN;
        end
    end

    assign slot_due = (state_q == ST_WAIT_SLOT) && (etu_cnt_q == start_q);

    // ==========================================================
    // State machine
    always_comb begin
        state_d = state_q;
        send_d = 1'b0;
        if (!fld_s2_q) begin
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: state_d = ST_IDLE;
                ST_IDLE, ST_WAIT_MARK, ST_WAIT_SLOT, ST_DECL, ST_HALT: begin
                    if (fr_ok && req_take) begin
                        state_d = req_next;
                        send_d = req_next == ST_DECL;
                    end else if (state_q == ST_WAIT_MARK && fr_ok && mark_hit) begin
                        state_d = ST_DECL;
                        send_d = 1'b1;
                    end else if (slot_due && !rx.eof) begin
                        state_d = ST_DECL;
                        send_d = 1'b1;
                    end else if (state_q == ST_DECL && fr_ok && attrib_hit) begin
                        state_d = ST_ACTIVE;
                    end else if (state_q == ST_DECL && fr_ok && hltb_hit) begin
                        state_d = ST_HALT;
                    end
                end
                ST_ACTIVE: begin
                    if (fr_ok && cid_ok && desel) begin
                        state_d = ST_HALT;
                    end else if (hl_idle_q) begin
                        state_d = ST_IDLE;
                    end else if (hl_halt_q) begin
                        state_d = ST_HALT;
                    end
                end
                default: state_d = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cid_q <= 4'h0;
        end else if (state_q == ST_DECL && fr_ok && attrib_hit && fld_s2_q) begin
            cid_q <= fr_q[ATTRIB_CID_BYTE][3:0];
        end
    end

    // ==========================================================
    // Transmit control
    logic tx_atqb_q, tx_gate_q, hl_rx_ok_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_atqb_q <= 1'b0;
            timed_q <= 1'b0;
            tx_gate_q <= 1'b0;
            hl_rx_ok_q <= 1'b0;
        end else begin
            tx_atqb_q <= send_d;
            hl_rx_ok_q <= hl_frame & fld_s2_q;
            if (send_d || rx.sof) begin
                timed_q <= send_d && state_q == ST_WAIT_SLOT;
            end
            if (!fld_s2_q) begin
                tx_gate_q <= 1'b0;
            end else if (send_d) begin
                tx_gate_q <= 1'b1;
            end else if (rx.sof) begin
                tx_gate_q <= 1'b0;
            end else if (timed_q && etu_cnt_q == close_q) begin
                tx_gate_q <= 1'b0;
            end else if (hl_frame) begin
                tx_gate_q <= 1'b1;
            end else if (rx.eof) begin
                tx_gate_q <= 1'b0;
            end
        end
    end

    assign tx_atqb = tx_atqb_q;
    assign tx_gate = tx_gate_q;
    assign hl_rx_ok = hl_rx_ok_q;
    assign card_state = state_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Checks
    field_loss_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        !fld_s2_q |=> state_q == ST_OFF) else $error("field loss did not power off");

    halt_field_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_HALT && !fld_s2_q |=> state_q == ST_OFF)
        else $error("halted card kept state after field loss");

    active_bad_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_ACTIVE && rx.eof && !rx.crc_ok |=> !tx_gate_q && !hl_rx_ok_q)
        else $error("active card answered bad frame");

    deselect_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_ACTIVE && fld_s2_q && fr_ok && cid_ok && desel |=> state_q == ST_HALT)
        else $error("deselect did not halt");

    active_no_atqb_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_ACTIVE |=> !tx_atqb_q) else $error("ATQB sent while active");

    active_stays_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_ACTIVE && fld_s2_q && !hl_idle_q && !hl_halt_q && !(fr_ok && desel)
        |=> state_q == ST_ACTIVE) else $error("active left without command");

    halt_only_wupb_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_HALT && fld_s2_q && !(fr_ok && req_ok && wupb)
        |=> state_q == ST_HALT) else $error("halt left without WUPB");

    bad_frame_ignored_a: assert property (@(posedge clk) disable iff (!arst_n)
        rx.eof && !rx.crc_ok && fld_s2_q && state_q != ST_WAIT_SLOT &&
        state_q != ST_OFF && !hl_idle_q && !hl_halt_q
        |=> $stable(state_q) && !tx_atqb_q) else $error("bad frame had effect");

    single_slot_a: assert property (@(posedge clk) disable iff (!arst_n)
        fr_ok && fld_s2_q && req_take && n_code == 3'h0
        |=> tx_atqb_q && state_q == ST_DECL) else $error("N=1 request not answered");

    quiet_guard_a: assert property (@(posedge clk) disable iff (!arst_n)
        timed_q && etu_cnt_q > close_q && !tx_atqb_q |-> !tx_gate_q)
        else $error("subcarrier allowed in closing guard");

    slot_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        slot_due && fld_s2_q && !rx.eof |=> tx_atqb_q && state_q == ST_DECL)
        else $error("timed slot missed");

    ext_afi_a: assert property (@(posedge clk) disable iff (!arst_n)
        ext_mode && fld_s2_q && state_q inside {ST_IDLE, ST_DECL} && fr_ok && req_ok &&
        req_afi != 8'h00 |=> $stable(state_q) && !tx_atqb_q) else $error("nonzero AFI accepted");

endmodule : tbac_card

// ---- verification/tbac_reader.sv ----
// Reader-side model: sends command frames to the card one byte a cycle
module tbac_reader (
    input wire logic clk,
    output tbac_pkg::tbac_rx_t rx
);
    timeunit 1ns;
    timeprecision 1ps;
    import tbac_pkg::*;

    initial rx = '0;

    // ==========================================================
    // Frame sender
    // Caller packs bytes right-justified, first byte on the wire leftmost
    task automatic send(input int len, input logic [127:0] b, input logic crc_good,
                        input logic fmt_good);
        int i;
        @(posedge clk);
        rx.sof <= 1'b1;
        for (i = 0; i < len; i++) begin
            @(posedge clk);
            rx.sof <= 1'b0;
            rx.valid <= 1'b1;
            rx.data <= b[8*(len-1-i) +: 8];
        end
        @(posedge clk);
        rx.valid <= 1'b0;
        // Idle byte lane never repeats the last byte
        rx.data <= ~rx.data;
        rx.eof <= 1'b1;
        rx.crc_ok <= crc_good;
        rx.fmt_ok <= fmt_good;
        @(posedge clk);
        rx.eof <= 1'b0;
        rx.crc_ok <= 1'b0;
        rx.fmt_ok <= 1'b0;
        rx.data <= rx.data + 8'h5A;
    endtask : send
endmodule : tbac_reader

// ---- verification/tbac_card_tb.sv ----
// Self-checking bench for the card anticollision block
module tbac_card_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tbac_pkg::*;

    // ==========================================================
    // Design, model and monitors
    localparam logic [31:0] OWN_PUPI = 32'h1234_5678;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic field_on = 1'b1;
    logic etu_clk = 1'b0;
    logic gate_q = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_atqb, tx_gate, hl_rx_ok;
    tbac_rx_t rx_w;
    tbac_state_t card_state;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0, etu_n = 0, n_atqb = 0, n_hl = 0, eof_cyc = 0, atqb_cyc = 0;
    int eof_etu = 0, atqb_etu = 0, gate_etu = 0;

    initial begin
        forever #10 clk = ~clk;
    end
    // Carrier-derived etu clock runs free, phase unrelated to clk
    initial begin
        #7;
        forever #80 etu_clk = ~etu_clk;
    end
    always @(posedge etu_clk) etu_n++;

    tbac_card dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .field_on(field_on), .etu_clk(etu_clk), .rx(rx_w),
        .tx_atqb(tx_atqb), .tx_gate(tx_gate), .hl_rx_ok(hl_rx_ok), .card_state(card_state));
    tbac_reader rdr (.clk(clk), .rx(rx_w));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        gate_q <= tx_gate;
        if (rx_w.eof) begin
            eof_cyc <= cyc;
            eof_etu <= etu_n;
        end
        if (tx_atqb === 1'b1) begin
            n_atqb <= n_atqb + 1;
            atqb_cyc <= cyc;
            atqb_etu <= etu_n;
        end
        if (hl_rx_ok === 1'b1) n_hl <= n_hl + 1;
        if (gate_q && tx_gate === 1'b0) gate_etu <= etu_n;
    end

    // ==========================================================
    // Compare, bus and frame tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic chk_st(input tbac_state_t e);
        chk("card state", {29'h0, e}, {29'h0, card_state});
    endtask : chk_st

    task automatic bail(input string what);
        fails++;
        $display("CHECK FAILED %s expected event seen timeout", what);
        test_done;
    endtask : bail

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bail("pready");
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic frm(input int len, input logic [127:0] b, input logic crc);
        rdr.send(len, b, crc, 1'b1);
        repeat (3) @(posedge clk);
    endtask : frm

    // Request: prefix, AFI, PARAM, two CRC bytes; reserved PARAM bits left clear
    task automatic req(input logic [7:0] pfx, input logic [7:0] afi, input logic [7:0] prm);
        frm(5, {88'h0, pfx, afi, prm, 16'hC3C3}, 1'b1);
    endtask : req

    task automatic to_active;
        req(PFX_REQ, 8'h00, 8'h08);
        frm(11, {40'h0, CMD_ATTRIB, OWN_PUPI, 32'h0000_0000, 16'hC3C3}, 1'b1);
    endtask : to_active

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, REG_CTRL, 32'h0, q, e);
        chk("ctrl reset", CTRL_RST, q);
        apb(1'b0, REG_PUPI, 32'h0, q, e);
        chk("pupi reset", PUPI_RST, q);
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        chk("status state", {29'h0, ST_IDLE}, {29'h0, q[2:0]});
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, REG_PUPI, OWN_PUPI, q, e);
        apb(1'b0, REG_PUPI, 32'h0, q, e);
        chk("pupi readback", OWN_PUPI, q);
        $display("test regs done");
    endtask : t_regs

    task automatic t_filter;
        logic [23:0] hdr [5] = '{24'h040000, 24'h0D0000, 24'h050005, 24'h050000, 24'h050000};
        logic crc [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic fmt [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        int a0;
        for (int i = 0; i < 5; i++) begin
            a0 = n_atqb;
            rdr.send(5, {88'h0, hdr[i], 16'hC3C3}, crc[i], fmt[i]);
            repeat (3) @(posedge clk);
            chk("ignored frame", 32'h0, n_atqb - a0);
            chk_st(ST_IDLE);
        end
        a0 = n_atqb;
        req(PFX_REQ, 8'h00, 8'h00);
        chk("one slot answer", 32'h1, n_atqb - a0);
        chk("answer latency", eof_cyc + 1, atqb_cyc);
        chk_st(ST_DECL);
        $display("test filter done");
    endtask : t_filter

    task automatic t_afi;
        logic [7:0] afi [5] = '{8'h10, 8'h13, 8'h00, 8'h12, 8'h20};
        int exp [5] = '{1, 0, 1, 1, 0};
        logic [31:0] q;
        logic e;
        int a0;
        apb(1'b1, REG_CTRL, 32'h0000_1200, q, e);
        for (int i = 0; i < 5; i++) begin
            a0 = n_atqb;
            req(PFX_REQ, afi[i], 8'h00);
            chk("afi answer", exp[i], n_atqb - a0);
        end
        apb(1'b1, REG_CTRL, 32'h0000_0001, q, e);
        a0 = n_atqb;
        req(PFX_REQ, 8'h10, 8'h00);
        chk("extended afi", 32'h0, n_atqb - a0);
        apb(1'b1, REG_CTRL, 32'h0, q, e);
        $display("test afi done");
    endtask : t_afi

    task automatic t_flow;
        logic [31:0] q;
        logic e;
        int a0;
        int h0;
        req(PFX_REQ, 8'h00, 8'h00);
        frm(11, {40'h0, CMD_ATTRIB, ~OWN_PUPI, 32'h0000_0000, 16'hC3C3}, 1'b1);
        chk_st(ST_DECL);
        frm(7, {72'h0, CMD_HLTB, OWN_PUPI, 16'hC3C3}, 1'b1);
        chk_st(ST_HALT);
        req(PFX_REQ, 8'h00, 8'h00);
        chk_st(ST_HALT);
        req(PFX_REQ, 8'h00, 8'h08);
        chk("woken by wupb", 32'h0, {31'h0, card_state === ST_HALT});
        to_active;
        chk_st(ST_ACTIVE);
        a0 = n_atqb;
        req(PFX_REQ, 8'h00, 8'h08);
        chk("active answer", 32'h0, n_atqb - a0);
        h0 = n_hl;
        frm(3, {104'h0, 8'h02, 16'hC3C3}, 1'b0);
        frm(4, {96'h0, 8'h0A, 8'h05, 16'hC3C3}, 1'b1);
        chk("silent frames", 32'h0, n_hl - h0);
        chk("gate silent", 32'h0, {31'h0, tx_gate});
        frm(3, {104'h0, 8'h02, 16'hC3C3}, 1'b1);
        chk("own frame", 32'h1, n_hl - h0);
        chk_st(ST_ACTIVE);
        apb(1'b1, REG_HLCMD, 32'h0000_0001, q, e);
        repeat (2) @(posedge clk);
        chk_st(ST_IDLE);
        to_active;
        apb(1'b1, REG_HLCMD, 32'h0000_0002, q, e);
        repeat (2) @(posedge clk);
        chk_st(ST_HALT);
        to_active;
        frm(3, {104'h0, PCB_DESEL, 16'hC3C3}, 1'b1);
        chk_st(ST_HALT);
        field_on <= 1'b0;
        for (int n = 0; n < 10 && card_state !== ST_OFF; n++) @(posedge clk);
        chk_st(ST_OFF);
        field_on <= 1'b1;
        repeat (8) @(posedge clk);
        chk_st(ST_IDLE);
        $display("test flow done");
    endtask : t_flow

    task automatic t_slots;
        logic [31:0] q;
        logic e;
        int a0;
        int d;
        for (int i = 0; i < 8; i++) begin
            a0 = n_atqb;
            req(PFX_REQ, 8'h00, 8'h01);
            chk("probabilistic", (n_atqb != a0) ? ST_DECL : ST_IDLE, card_state);
        end
        apb(1'b1, REG_CTRL, 32'h0000_0002, q, e);
        for (int i = 0; i < 8 && card_state !== ST_WAIT_MARK; i++) req(PFX_REQ, 8'h00, 8'h01);
        chk_st(ST_WAIT_MARK);
        a0 = n_atqb;
        frm(3, {104'h0, 8'h25, 16'hC3C3}, 1'b1);
        chk_st(ST_WAIT_MARK);
        frm(3, {104'h0, 8'h15, 16'hC3C3}, 1'b1);
        chk("marker answer", 32'h1, n_atqb - a0);
        chk_st(ST_DECL);
        apb(1'b1, REG_CTRL, 32'h0000_0001, q, e);
        req(PFX_REQ, 8'h00, 8'h01);
        chk("untimed", 32'h0, {31'h0, card_state === ST_WAIT_SLOT});
        a0 = n_atqb;
        req(PFX_REQ, 8'h00, 8'h12);
        for (int n = 0; n < 12000 && n_atqb == a0; n++) @(posedge clk);
        if (n_atqb == a0) bail("timed answer");
        d = atqb_etu - eof_etu;
        chk_rng("slot offset", 0, 1, (d - 31) % 240);
        chk_rng("slot index", 0, 3, (d - 31) / 240);
        for (int n = 0; n < 3000 && tx_gate !== 1'b0; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk_rng("gate close", 200, 230, gate_etu - atqb_etu);
        $display("test slots done");
    endtask : t_slots

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_regs;
        t_filter;
        t_afi;
        t_flow;
        t_slots;
        test_done;
    end
endmodule : tbac_card_tb
